// *** include/sps_pkg.sv ***
// package: supply protection sequencer constants and types
`default_nettype none
package sps_pkg;
  localparam int CLK_MHZ = 250;
  localparam int RESTART_MS = 1000;
  localparam int OVP_BLANK_US = 30;
  localparam int OCP_PERSIST_MS = 25;
  localparam int BUS_DISCHARGE_PERIOD_MS = 1;
  localparam int BUS_DISCHARGE_SAMPLE_US = 20;
  localparam int US_CYC = CLK_MHZ;
  localparam int OVP_BLANK_CYC = OVP_BLANK_US * CLK_MHZ;
  localparam int BUS_DISCHARGE_SAMPLE_CYC = BUS_DISCHARGE_SAMPLE_US * CLK_MHZ;
  localparam int RESTART_US = RESTART_MS * 1000;
  localparam int OCP_PERSIST_US = OCP_PERSIST_MS * 1000;
  localparam int BUS_DISCHARGE_PERIOD_US = BUS_DISCHARGE_PERIOD_MS * 1000;
  localparam int PROT_LIMIT = 7;
  localparam logic [2:0] PROT_LIMIT_W = 3'h7;
  localparam logic [3:0] PDO_DEFAULT = 4'h0;
  localparam logic [7:0] TEMP_FIXED_C = 8'h19;
  localparam logic [7:0] CC_MARGIN_NUM = 8'h69;
  localparam logic [7:0] CC_MARGIN_DEN_SH = 8'h64;

  typedef enum logic [2:0] {
    SPS_OFF, SPS_RUN, SPS_RESTART, SPS_THERM_HOLD, SPS_LATCHED, SPS_COUNT_LOCK
  } sps_state_t;

  typedef struct packed {
    logic lockout_low;
    logic ovp_trip;
    logic uvp_trip;
    logic ocp_trip;
    logic supply_ok;
    logic int_hot;
    logic ext_hot;
    logic ext_warm;
  } sps_sense_t;

  typedef struct packed {
    logic load_switch_on;
    logic regulate_5v;
    logic sink_on;
    logic bus_discharge;
    logic bus_discharge_sample;
    logic latched;
  } sps_ctrl_t;
endpackage
`default_nettype wire

// *** rtl/sps_sequencer.sv ***
// protection sequencer: fault blanking, safe restart and latched shutdown
`default_nettype none
module sps_sequencer #(
  parameter int RESTART_US = sps_pkg::RESTART_US,
  parameter int OCP_US = sps_pkg::OCP_PERSIST_US,
  parameter int BUS_DISCHARGE_US = sps_pkg::BUS_DISCHARGE_PERIOD_US,
  parameter bit DUAL_THERM = 1'b1
) (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic nrst,
  // comparator and sense pins, asynchronous
  input wire sps_pkg::sps_sense_t sense_in,
  input wire logic cable_attached,
  // contract side
  input wire logic contract_done,
  input wire logic pd_mode,
  input wire logic pps_mode,
  input wire logic [3:0] contract_index,
  input wire logic [11:0] contracted_current,
  // temperature reporting
  input wire logic temp_request,
  input wire logic fixed_resistor,
  input wire logic [7:0] first_thermistor_input,
  input wire logic [7:0] second_thermistor_input,
  // outputs
  output sps_pkg::sps_ctrl_t ctrl,
  output logic [3:0] active_index_q,
  output logic [15:0] current_limit_q,
  output logic [7:0] connector_temp_q,
  output logic [7:0] adapter_temp_q,
  output logic temp_valid_q,
  output logic [2:0] prot_count_q
);
  // ************************************************
  // input synchronisers
  // ************************************************
  sps_pkg::sps_sense_t s1_q, s_q;
  logic att1_q, att_q;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= '0;
      s_q <= '0;
      att1_q <= 1'b0;
      att_q <= 1'b0;
    end
    else
    begin
      s1_q <= sense_in;
      s_q <= s1_q;
      att1_q <= cable_attached;
      att_q <= att1_q;
    end
  end

  // ************************************************
  // microsecond tick and timers
  // ************************************************
  logic [7:0] pre_q;
  logic us_tick;
  sps_pkg::sps_state_t st_q;
  logic restart_done, ocp_done, bus_discharge_done;
  logic [12:0] ovp_q;
  logic ovp_fire;
  logic [12:0] samp_q;

  assign us_tick = (pre_q == 8'(sps_pkg::US_CYC - 1));

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      pre_q <= '0;
    else if (us_tick)
      pre_q <= '0;
    else
      pre_q <= pre_q + 8'h01;
  end

  sps_timer #(.W(20)) u_restart (
    .mclk(mclk), .nrst(nrst), .clear(1'b0),
    .run(st_q == sps_pkg::SPS_RESTART), .tick(us_tick),
    .limit(20'(RESTART_US)), .done(restart_done)
  );

  sps_timer #(.W(20)) u_ocp (
    .mclk(mclk), .nrst(nrst), .clear(1'b0),
    .run(s_q.ocp_trip && st_q == sps_pkg::SPS_RUN), .tick(us_tick),
    .limit(20'(OCP_US)), .done(ocp_done)
  );

  sps_timer #(.W(20)) u_bus_discharge (
    .mclk(mclk), .nrst(nrst), .clear(bus_discharge_done),
    .run(ctrl.bus_discharge), .tick(us_tick),
    .limit(20'(BUS_DISCHARGE_US)), .done(bus_discharge_done)
  );

  // over-voltage blanking counted in raw clocks for resolution
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ovp_q <= '0;
    else if (!s_q.ovp_trip || st_q != sps_pkg::SPS_RUN)
      ovp_q <= '0;
    else if (ovp_q != 13'(sps_pkg::OVP_BLANK_CYC))
      ovp_q <= ovp_q + 13'h0001;
  end
  assign ovp_fire = (ovp_q == 13'(sps_pkg::OVP_BLANK_CYC)) && s_q.ovp_trip;

  // ************************************************
  // fault decode
  // ************************************************
  logic uvp_fire, restart_fault, fault_now, attach_fall;
  logic att_d1_q, comm_seen_q;
  localparam logic [2:0] PROT_LIMIT_M1 = sps_pkg::PROT_LIMIT_W - 3'h1;

  assign uvp_fire = s_q.uvp_trip && (active_index_q > 4'h1);
  assign restart_fault = uvp_fire || ovp_fire || ocp_done || s_q.ext_hot;
  assign attach_fall = att_d1_q && !att_q;
  assign fault_now = restart_fault || s_q.lockout_low || s_q.int_hot;

  // ************************************************
  // main sequencer
  // ************************************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      st_q <= sps_pkg::SPS_OFF;
    else
    begin
      case (st_q)
        sps_pkg::SPS_OFF:
          if (!s_q.lockout_low && s_q.supply_ok)
            st_q <= sps_pkg::SPS_RESTART;
        sps_pkg::SPS_RUN:
          if (s_q.int_hot)
            st_q <= sps_pkg::SPS_LATCHED;
          else if (s_q.lockout_low)
            st_q <= sps_pkg::SPS_OFF;
          else if (restart_fault)
            st_q <= (pd_mode && prot_count_q == PROT_LIMIT_M1) ?
                    sps_pkg::SPS_COUNT_LOCK : sps_pkg::SPS_RESTART;
        sps_pkg::SPS_RESTART:
          if (s_q.int_hot)
            st_q <= sps_pkg::SPS_LATCHED;
          else if (restart_done)
            st_q <= s_q.ext_warm ? sps_pkg::SPS_THERM_HOLD : sps_pkg::SPS_RUN;
        sps_pkg::SPS_THERM_HOLD:
          if (s_q.int_hot)
            st_q <= sps_pkg::SPS_LATCHED;
          else if (!s_q.ext_warm)
            st_q <= sps_pkg::SPS_RUN;
        sps_pkg::SPS_LATCHED:
          st_q <= sps_pkg::SPS_LATCHED;
        sps_pkg::SPS_COUNT_LOCK:
          if (s_q.int_hot)
            st_q <= sps_pkg::SPS_LATCHED;
          else if (attach_fall)
            st_q <= sps_pkg::SPS_RESTART;
        default:
          st_q <= sps_pkg::SPS_OFF;
      endcase
    end
  end

  // ************************************************
  // protection counter and attach tracking
  // ************************************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      prot_count_q <= '0;
      att_d1_q <= 1'b0;
    end
    else
    begin
      att_d1_q <= att_q;
      if (st_q == sps_pkg::SPS_RUN && restart_fault && pd_mode
          && prot_count_q != sps_pkg::PROT_LIMIT_W)
        prot_count_q <= prot_count_q + 3'h1;
      else if (attach_fall)
        prot_count_q <= '0;
    end
  end

  // ************************************************
  // contract level tracking
  // ************************************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      comm_seen_q <= 1'b0;
    else if (st_q != sps_pkg::SPS_RUN)
      comm_seen_q <= 1'b0;
    else if (contract_done)
      comm_seen_q <= 1'b1;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      active_index_q <= sps_pkg::PDO_DEFAULT;
    else if (!comm_seen_q)
      active_index_q <= sps_pkg::PDO_DEFAULT;
    else
      active_index_q <= contract_index;
  end

  // margin 1.05 as 105/100: multiply by 105, then divide by 100 in the limit path
  logic [19:0] cur_scaled;
  assign cur_scaled = 20'(contracted_current) * 20'(sps_pkg::CC_MARGIN_NUM);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      current_limit_q <= '0;
    else if (pps_mode)
      current_limit_q <= 16'(contracted_current);
    else
      current_limit_q <= 16'(cur_scaled / 20'(sps_pkg::CC_MARGIN_DEN_SH));
  end

  // ************************************************
  // switch and discharge outputs
  // ************************************************
  logic samp_d;
  assign samp_d = (st_q == sps_pkg::SPS_RESTART)
                  && (bus_discharge_done || (ctrl.bus_discharge_sample && samp_q != '0));

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ctrl <= '0;
    else
    begin
      // supply loss needs no blanking, so it gates the switch directly
      ctrl.load_switch_on <= (st_q == sps_pkg::SPS_RUN) && !fault_now
                             && s_q.supply_ok;
      ctrl.regulate_5v <= (st_q != sps_pkg::SPS_RUN) || !comm_seen_q;
      ctrl.sink_on <= (st_q == sps_pkg::SPS_RESTART) || (st_q == sps_pkg::SPS_LATCHED);
      // discharge switch opens while the bus is sampled, clearing the period timer
      ctrl.bus_discharge <= (st_q == sps_pkg::SPS_RESTART) && !samp_d;
      ctrl.bus_discharge_sample <= samp_d;
      ctrl.latched <= (st_q == sps_pkg::SPS_LATCHED);
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      samp_q <= '0;
    else if (bus_discharge_done)
      samp_q <= 13'(sps_pkg::BUS_DISCHARGE_SAMPLE_CYC - 1);
    else if (samp_q != '0)
      samp_q <= samp_q - 13'h0001;
  end

  // ************************************************
  // temperature reporting
  // ************************************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      connector_temp_q <= '0;
      adapter_temp_q <= '0;
      temp_valid_q <= 1'b0;
    end
    else
    begin
      temp_valid_q <= temp_request;
      if (temp_request)
      begin
        connector_temp_q <= fixed_resistor ? sps_pkg::TEMP_FIXED_C
                                           : first_thermistor_input;
        adapter_temp_q <= !DUAL_THERM ? 8'h00 :
                          fixed_resistor ? sps_pkg::TEMP_FIXED_C
                                         : second_thermistor_input;
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/sps_timer.sv ***
// reusable interval timer counting microsecond ticks or clocks
`default_nettype none
module sps_timer #(
  parameter int W = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // control
  input wire logic clear,
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  // result
  output logic done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= '0;
      done <= 1'b0;
    end
    else if (clear || !run)
    begin
      cnt_q <= '0;
      done <= 1'b0;
    end
    else if (tick && !done)
    begin
      if (cnt_q >= limit - W'(1))
        done <= 1'b1;
      else
        cnt_q <= cnt_q + W'(1);
    end
  end
endmodule
`default_nettype wire

// *** tb/sps_load_model.sv ***
// partner model: converter output and bus load switch
`default_nettype none
module sps_load_model (
  // switch state
  input wire sps_pkg::sps_ctrl_t ctrl,
  // bench faults
  input wire logic [7:0] fault,
  // comparator levels
  output sps_pkg::sps_sense_t sense
);
  always_comb
  begin
    sense = sps_pkg::sps_sense_t'(fault);
    // bit 3 commands a supply loss
    sense.supply_ok = ~fault[3];
    // overload current flows only through a closed switch
    sense.ocp_trip = fault[4] & ctrl.load_switch_on;
    // above trip level is also above release level
    sense.ext_warm = fault[0] | fault[1];
  end
endmodule
`default_nettype wire

// *** tb/sps_sequencer_assertions.sv ***
// checker: output timing of the protection sequencer
`default_nettype none
module sps_sequencer_assertions #(
  parameter int RESTART_US = 50
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // inputs
  input wire sps_pkg::sps_sense_t sense_in,
  input wire logic pps_mode,
  input wire logic [11:0] contracted_current,
  input wire logic temp_request,
  input wire logic fixed_resistor,
  input wire logic [7:0] first_thermistor_input,
  // outputs
  input wire sps_pkg::sps_ctrl_t ctrl,
  input wire logic [3:0] active_index_q,
  input wire logic [15:0] current_limit_q,
  input wire logic [7:0] connector_temp_q,
  input wire logic temp_valid_q,
  input wire logic [2:0] prot_count_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  int ovp_n;
  int sink_n;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ovp_n <= 0;
      sink_n <= 0;
    end
    else
    begin
      ovp_n <= sense_in.ovp_trip ? ovp_n + 1 : 0;
      // only restart time counts: a supply dip resumes without a restart
      sink_n <= ctrl.load_switch_on ? 0 : sink_n + (ctrl.sink_on ? 1 : 0);
    end
  end
  AST_LOCK_OPEN: assert property ($rose(sense_in.lockout_low) |-> ##[0:3]
    !ctrl.load_switch_on) else $error("lockout left switch closed");
  AST_SUPPLY_OPEN: assert property ($fell(sense_in.supply_ok) |-> ##[0:3]
    !ctrl.load_switch_on) else $error("supply loss left switch closed");
  AST_HOT_LATCH: assert property ($rose(sense_in.int_hot) |-> ##[0:4]
    ctrl.latched) else $error("no latch on internal heat");
  AST_LATCH_HOLD: assert property (ctrl.latched |=> ctrl.latched
    && !ctrl.load_switch_on) else $error("latched state left");
  AST_OVP_BLANK: assert property ($fell(ctrl.load_switch_on) && sense_in.ovp_trip
    |-> ovp_n >= sps_pkg::OVP_BLANK_CYC) else $error("ovp blanking too short");
  AST_OVP_OPEN: assert property (ovp_n == sps_pkg::OVP_BLANK_CYC + 20
    |-> !ctrl.load_switch_on) else $error("ovp did not open switch");
  AST_RESTART: assert property ($rose(ctrl.load_switch_on) && sink_n != 0
    |-> sink_n >= (RESTART_US - 1) * sps_pkg::US_CYC) else $error("restart too short");
  AST_PDO0: assert property ($rose(ctrl.load_switch_on) |-> ctrl.regulate_5v
    && active_index_q == sps_pkg::PDO_DEFAULT) else $error("not default contract");
  AST_TEMP: assert property (temp_request |-> ##[1:2] temp_valid_q &&
    connector_temp_q == (fixed_resistor ? sps_pkg::TEMP_FIXED_C : first_thermistor_input))
    else $error("temperature report wrong");
  AST_LIMIT: assert property (($stable(contracted_current) && $stable(pps_mode))[*4]
    |-> current_limit_q == (pps_mode ? 16'(contracted_current) :
    16'(contracted_current * 105 / 100))) else $error("current limit wrong");
  AST_COUNT_LOCK: assert property (prot_count_q == sps_pkg::PROT_LIMIT_W
    |-> !ctrl.load_switch_on) else $error("count lock switch closed");
  AST_BUS_DISCHARGE: assert property (ctrl.bus_discharge_sample |-> !ctrl.load_switch_on)
    else $error("sampling with switch closed");
  AST_BUS_DISCHARGE_GAP: assert property (ctrl.bus_discharge_sample |-> !ctrl.bus_discharge)
    else $error("discharge switch closed while sampling");
endmodule
bind sps_sequencer sps_sequencer_assertions #(.RESTART_US(RESTART_US)) u_sps_chk (
  .mclk(mclk), .nrst(nrst), .sense_in(sense_in), .pps_mode(pps_mode),
  .contracted_current(contracted_current), .temp_request(temp_request),
  .fixed_resistor(fixed_resistor), .first_thermistor_input(first_thermistor_input),
  .ctrl(ctrl), .active_index_q(active_index_q), .current_limit_q(current_limit_q),
  .connector_temp_q(connector_temp_q), .temp_valid_q(temp_valid_q),
  .prot_count_q(prot_count_q));
`default_nettype wire

// *** tb/test_supply_protection_sequencer.sv ***
// testbench: protection scenarios against the load model
`default_nettype none
module test_supply_protection_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] fault = 8'h00;
  logic pd_mode = 1'b0;
  logic pps_mode = 1'b0;
  logic temp_request = 1'b0;
  logic fixed_resistor = 1'b0;
  logic cable_attached = 1'b1;
  logic contract_done = 1'b0;
  sps_pkg::sps_sense_t sense;
  sps_pkg::sps_ctrl_t ctrl;
  logic [3:0] idx;
  logic [15:0] lim;
  logic [7:0] t_con;
  logic [7:0] t_adp;
  logic t_val;
  logic [2:0] cnt;
  int mismatches = 0;
  int comparisons = 0;
  int n;
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  // restart shortened to 20 us to keep the run short
  sps_sequencer #(.RESTART_US(20), .OCP_US(20), .BUS_DISCHARGE_US(5)) u_sps_sequencer (
    .mclk(mclk), .nrst(nrst), .sense_in(sense), .cable_attached(cable_attached),
    .contract_done(contract_done), .pd_mode(pd_mode), .pps_mode(pps_mode),
    .contract_index(4'h3), .contracted_current(12'h0C8), .temp_request(temp_request),
    .fixed_resistor(fixed_resistor), .first_thermistor_input(8'h28),
    .second_thermistor_input(8'h37), .ctrl(ctrl), .active_index_q(idx),
    .current_limit_q(lim), .connector_temp_q(t_con), .adapter_temp_q(t_adp),
    .temp_valid_q(t_val), .prot_count_q(cnt));
  sps_load_model u_sps_load_model (.ctrl(ctrl), .fault(fault), .sense(sense));
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_sw(input logic v, input int bound);
    n = 0;
    while (ctrl.load_switch_on !== v && n < bound)
    begin
      step(1);
      n++;
    end
    if (n >= bound)
    begin
      mismatches++;
      $display("ERROR load_switch_on expected %0b seen %0b", v, ctrl.load_switch_on);
      end_of_test();
    end
  endtask
  task automatic t_start;
    step(2);
    chk("ctrl in reset", 16'h0000, 16'(ctrl));
    step(1);
    nrst = 1'b1;
    wait_sw(1'b1, 8000);
    chk("startup delay", 16'h0001, 16'(n >= 4750));
    chk("regulate_5v", 16'h0001, 16'(ctrl.regulate_5v));
    chk("active_index", 16'h0000, 16'(idx));
    chk("current_limit", 16'h00D2, lim);
    pps_mode = 1'b1;
    step(6);
    chk("pps limit", 16'h00C8, lim);
    pps_mode = 1'b0;
  endtask
  task automatic t_temp;
    for (int f = 0; f < 2; f++)
    begin
      fixed_resistor = f[0];
      temp_request = 1'b1;
      step(1);
      temp_request = 1'b0;
      chk("temp_valid", 16'h0001, 16'(t_val));
      chk("connector", (f == 1) ? 16'h0019 : 16'h0028, 16'(t_con));
      chk("adapter", (f == 1) ? 16'h0019 : 16'h0037, 16'(t_adp));
      step(2);
    end
  endtask
  task automatic t_lock;
    fault = 8'h20;
    step(20);
    chk("uvp on index 0", 16'h0001, 16'(ctrl.load_switch_on));
    fault = 8'h80;
    step(3);
    chk("lockout open", 16'h0000, 16'(ctrl.load_switch_on));
    fault = 8'h00;
    wait_sw(1'b1, 8000);
    chk("lockout restart", 16'h0001, 16'(n >= 4750));
    contract_done = 1'b1;
    step(1);
    contract_done = 1'b0;
    step(3);
    chk("contract index", 16'h0003, 16'(idx));
    chk("contract level", 16'h0000, 16'(ctrl.regulate_5v));
    fault = 8'h20;
    step(4);
    chk("uvp on index 3", 16'h0000, 16'(ctrl.load_switch_on));
    fault = 8'h00;
    wait_sw(1'b1, 8000);
  endtask
  task automatic t_ovp;
    pd_mode = 1'b1;
    fault = 8'h40;
    step(1000);
    fault = 8'h00;
    step(5);
    chk("ovp blanked", 16'h0001, 16'(ctrl.load_switch_on));
    fault = 8'h40;
    wait_sw(1'b0, 8000);
    chk("ovp delay", 16'h0001, 16'(n >= 7500));
    fault = 8'h00;
    step(5);
    chk("prot_count", 16'h0001, 16'(cnt));
    wait_sw(1'b1, 8000);
    chk("ovp retry", 16'h0001, 16'(n >= 4740));
    pd_mode = 1'b0;
  endtask
  task automatic overcurrent_persist_time;
    logic seen;
    seen = 1'b0;
    fault = 8'h10;
    wait_sw(1'b0, 6000);
    chk("ocp delay", 16'h0001, 16'(n >= 4750));
    fault = 8'h00;
    step(3);
    chk("ocp 5v", 16'h0001, 16'(ctrl.regulate_5v));
    chk("sink_on", 16'h0001, 16'(ctrl.sink_on));
    chk("bus_discharge", 16'h0001, 16'(ctrl.bus_discharge));
    for (int i = 0; i < 8000 && ctrl.load_switch_on !== 1'b1; i++)
    begin
      seen = seen | (ctrl.bus_discharge_sample === 1'b1);
      step(1);
    end
    chk("bus_discharge_sample", 16'h0001, 16'(seen));
    wait_sw(1'b1, 10);
  endtask
  task automatic t_therm;
    fault = 8'h02;
    step(4);
    chk("ntc open", 16'h0000, 16'(ctrl.load_switch_on));
    fault = 8'h01;
    step(8000);
    chk("start held", 16'h0000, 16'(ctrl.load_switch_on));
    fault = 8'h00;
    wait_sw(1'b1, 8000);
    fault = 8'h08;
    step(3);
    chk("supply loss", 16'h0000, 16'(ctrl.load_switch_on));
    fault = 8'h00;
    wait_sw(1'b1, 10);
  endtask
  task automatic t_count;
    pd_mode = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      fault = 8'h02;
      step(4);
      fault = 8'h00;
      if (i < 5)
        wait_sw(1'b1, 8000);
    end
    step(6000);
    chk("count lock", 16'h0007, 16'(cnt));
    chk("count open", 16'h0000, 16'(ctrl.load_switch_on));
    cable_attached = 1'b0;
    step(4);
    chk("count clear", 16'h0000, 16'(cnt));
    cable_attached = 1'b1;
    wait_sw(1'b1, 8000);
    pd_mode = 1'b0;
  endtask
  task automatic t_latch;
    fault = 8'h04;
    step(3);
    fault = 8'h00;
    step(100);
    chk("latched", 16'h0001, 16'(ctrl.latched));
    chk("latch open", 16'h0000, 16'(ctrl.load_switch_on));
    nrst = 1'b0;
    step(1);
    nrst = 1'b1;
    step(1);
    chk("latch cleared", 16'h0000, 16'(ctrl.latched));
  endtask
  initial
  begin
    t_start();
    t_temp();
    t_lock();
    t_ovp();
    overcurrent_persist_time();
    t_therm();
    t_count();
    t_latch();
    end_of_test();
  end
endmodule
`default_nettype wire
